/* File: design/oag_operand_address_generator.sv */
`timescale 1ns/1ns
`default_nettype none
module oag_operand_address_generator
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire oag_pkg::oag_instr_t instr,
   input wire logic instr_valid,
   output logic instr_ready,
   output logic [14:0] pmem_addr,
   output logic pmem_rd,
   input wire logic [7:0] pmem_rdata,
   output oag_pkg::oag_dmem_req_t dmem_req,
   input wire logic [7:0] dmem_rdata,
   output logic [7:0] acc,
   output logic [7:0] x_ptr,
   output logic [7:0] b_ptr,
   output logic [7:0] stack_pointer,
   output logic [7:0] seg_reg,
   output logic [14:0] pc,
   output logic bit_test_result,
   output logic done
);

   oag_pkg::oag_state_t state;
   oag_pkg::oag_instr_t cur;
   logic [7:0] cur_addr;
   // General register RAM of the window, twelve bytes
   logic [7:0] reg_file [0:11];
   logic [7:0] mapped_rdata;
   logic mapped_hit;
   logic [7:0] rd_byte;
   logic is_mem_op;
   logic [7:0] next_wdata;
   logic [7:0] issue_addr;

   function automatic logic [7:0] oag_post_mod(input logic [7:0] p, input oag_pkg::oag_post_t m);
      case (m)
         oag_pkg::OAG_PM_INC: oag_post_mod = 8'(p + 8'h01);
         oag_pkg::OAG_PM_DEC: oag_post_mod = 8'(p - 8'h01);
         default: oag_post_mod = p;
      endcase
   endfunction : oag_post_mod

   function automatic logic oag_is_mem(input oag_pkg::oag_op_t o);
      case (o)
         oag_pkg::OAG_OP_LD_DIR, oag_pkg::OAG_OP_LD_IND, oag_pkg::OAG_OP_XCH_DIR,
         oag_pkg::OAG_OP_XCH_IND, oag_pkg::OAG_OP_BIT_SET, oag_pkg::OAG_OP_BIT_CLR,
         oag_pkg::OAG_OP_BIT_TST, oag_pkg::OAG_OP_ST_DIR: oag_is_mem = 1'b1;
         default: oag_is_mem = 1'b0;
      endcase
   endfunction : oag_is_mem

   function automatic logic oag_is_ind(input oag_pkg::oag_op_t o);
      oag_is_ind = (o == oag_pkg::OAG_OP_LD_IND) || (o == oag_pkg::OAG_OP_XCH_IND);
   endfunction : oag_is_ind

   // Ops that put a byte back: exchange, bit set and clear, store
   function automatic logic oag_writes_back(input oag_pkg::oag_op_t o);
      case (o)
         oag_pkg::OAG_OP_XCH_DIR,
         oag_pkg::OAG_OP_XCH_IND,
         oag_pkg::OAG_OP_BIT_SET,
         oag_pkg::OAG_OP_BIT_CLR,
         oag_pkg::OAG_OP_ST_DIR: oag_writes_back = 1'b1;
         default: oag_writes_back = 1'b0;
      endcase
   endfunction : oag_writes_back

   // Ops that need an access cycle after issue; the rest retire at once
   function automatic logic oag_needs_access(input oag_pkg::oag_op_t o);
      case (o)
         oag_pkg::OAG_OP_LD_IMM,
         oag_pkg::OAG_OP_TABLE_READ: oag_needs_access = 1'b1;
         default: oag_needs_access = oag_is_mem(o);
      endcase
   endfunction : oag_needs_access

   // The top sixteen bytes are served inside the block, never on the bus
   function automatic logic oag_in_window(input logic [7:0] a);
      oag_in_window = (a >= oag_pkg::OAG_REG_BASE);
   endfunction : oag_in_window

   // Combinational ready lets the next op in on the edge after done rises
   assign instr_ready = (state == oag_pkg::OAG_ST_ISSUE);
   assign is_mem_op = oag_is_mem(instr.op);
   assign issue_addr = oag_is_ind(instr.op) ? (instr.use_x ? x_ptr : b_ptr) : instr.operand;

   // Register-mapped window answers locally; the rest goes to data memory
   always_comb
   begin
      mapped_hit = oag_in_window(cur_addr);
      case (cur_addr)
         oag_pkg::OAG_ADDR_XPTR: mapped_rdata = x_ptr;
         oag_pkg::OAG_ADDR_SP: mapped_rdata = stack_pointer;
         oag_pkg::OAG_ADDR_BPTR: mapped_rdata = b_ptr;
         oag_pkg::OAG_ADDR_SEG: mapped_rdata = seg_reg;
         default: mapped_rdata = mapped_hit ? reg_file[cur_addr[3:0]] : 8'h00;
      endcase
      // Window bytes never depend on the bus, so stale bus data cannot leak in
      rd_byte = mapped_hit ? mapped_rdata : dmem_rdata;
   end

   // Byte to put back in the write phase
   always_comb
   begin
      case (cur.op)
         oag_pkg::OAG_OP_XCH_DIR, oag_pkg::OAG_OP_XCH_IND: next_wdata = acc;
         oag_pkg::OAG_OP_BIT_SET: next_wdata = rd_byte | (8'h01 << cur.bit_sel);
         oag_pkg::OAG_OP_BIT_CLR: next_wdata = rd_byte & ~(8'h01 << cur.bit_sel);
         oag_pkg::OAG_OP_ST_DIR: next_wdata = acc;
         default: next_wdata = rd_byte;
      endcase
   end

   // Sequencer: ops other than memory ops, immediate load and table read retire in the issue cycle
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state <= oag_pkg::OAG_ST_ISSUE;
         cur <= '0;
         cur_addr <= 8'h00;
      end
      else
      begin
         case (state)
            // Anything offered outside this state is refused, not queued
            oag_pkg::OAG_ST_ISSUE:
            begin
               if (instr_valid && oag_needs_access(instr.op))
               begin
                  cur <= instr;
                  state <= oag_pkg::OAG_ST_ACCESS;
                  if (oag_is_ind(instr.op))
                     cur_addr <= instr.use_x ? x_ptr : b_ptr;
                  else
                     cur_addr <= instr.operand;
               end
            end
            oag_pkg::OAG_ST_ACCESS:
            begin
               if (oag_writes_back(cur.op))
                  state <= oag_pkg::OAG_ST_WRITE;
               else
                  state <= oag_pkg::OAG_ST_ISSUE;
            end
            oag_pkg::OAG_ST_WRITE: state <= oag_pkg::OAG_ST_ISSUE;
            default: state <= oag_pkg::OAG_ST_ISSUE;
         endcase
      end
   end

   // Memory and program-memory strobes
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         dmem_req <= '0;
         pmem_rd <= 1'b0;
         pmem_addr <= oag_pkg::OAG_RST_PC;
      end
      else
      begin
         dmem_req.rd <= 1'b0;
         dmem_req.wr <= 1'b0;
         pmem_rd <= 1'b0;
         if (state == oag_pkg::OAG_ST_ISSUE && instr_valid && is_mem_op)
         begin
            // A window hit would put the bus on a byte that memory does not own
            dmem_req.rd <= (instr.op != oag_pkg::OAG_OP_ST_DIR)
                           && !oag_in_window(issue_addr);
            dmem_req.addr <= issue_addr;
         end
         else if (state == oag_pkg::OAG_ST_ISSUE && instr_valid
                  && instr.op == oag_pkg::OAG_OP_LD_IMM)
         begin
            pmem_rd <= 1'b1;
            pmem_addr <= 15'(pc + 15'h0001);
         end
         else if (state == oag_pkg::OAG_ST_ISSUE && instr_valid
                  && instr.op == oag_pkg::OAG_OP_TABLE_READ)
         begin
            pmem_rd <= 1'b1;
            pmem_addr <= {pc[14:8], acc};
         end
         // A bit op that changes nothing skips the bus write
         else if (state == oag_pkg::OAG_ST_ACCESS && !mapped_hit
                  && oag_is_mem(cur.op) && next_wdata != rd_byte)
         begin
            dmem_req.wr <= 1'b1;
            dmem_req.wdata <= next_wdata;
         end
         else if (state == oag_pkg::OAG_ST_ACCESS && !mapped_hit
                  && (cur.op == oag_pkg::OAG_OP_XCH_DIR || cur.op == oag_pkg::OAG_OP_XCH_IND
                      || cur.op == oag_pkg::OAG_OP_ST_DIR))
         begin
            dmem_req.wr <= 1'b1;
            dmem_req.wdata <= next_wdata;
         end
      end
   end

   // Accumulator and program counter
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         acc <= oag_pkg::OAG_RST_ACC;
         pc <= oag_pkg::OAG_RST_PC;
         bit_test_result <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (state == oag_pkg::OAG_ST_ISSUE && instr_valid && !oag_needs_access(instr.op))
         begin
            pc <= 15'(pc + 15'h0001);
            done <= 1'b1;
         end
         if (state == oag_pkg::OAG_ST_ACCESS)
         begin
            case (cur.op)
               oag_pkg::OAG_OP_LD_DIR, oag_pkg::OAG_OP_LD_IND,
               oag_pkg::OAG_OP_XCH_DIR, oag_pkg::OAG_OP_XCH_IND: acc <= rd_byte;
               oag_pkg::OAG_OP_LD_IMM: acc <= pmem_rdata;
               // Table data lands here; the pc low byte never leaves its register
               oag_pkg::OAG_OP_TABLE_READ: acc <= pmem_rdata;
               oag_pkg::OAG_OP_BIT_TST: bit_test_result <= rd_byte[cur.bit_sel];
               default: acc <= acc;
            endcase
            // Table read advances pc by one like a single-byte op; immediate load advances it by two
            pc <= (cur.op == oag_pkg::OAG_OP_LD_IMM) ? 15'(pc + 15'h0002)
                                                     : 15'(pc + 15'h0001);
            // Write-back ops retire a cycle later, from the write phase
            if (!oag_writes_back(cur.op))
               done <= 1'b1;
         end
         if (state == oag_pkg::OAG_ST_WRITE)
            done <= 1'b1;
      end
   end

   // Pointers and register-mapped RAM
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         // X and B pointers come out of reset at the bottom of the segment; the stack pointer at 6F
         x_ptr <= oag_pkg::OAG_RST_PTR;
         b_ptr <= oag_pkg::OAG_RST_PTR;
         stack_pointer <= oag_pkg::OAG_RST_SP;
         seg_reg <= oag_pkg::OAG_RST_PTR;
         for (int i = 0; i < 12; i++)
            reg_file[i] <= 8'h00;
      end
      else
      begin
         // Short load reaches only the primary pointer
         if (state == oag_pkg::OAG_ST_ISSUE && instr_valid
             && instr.op == oag_pkg::OAG_OP_LD_BSHORT)
            b_ptr <= {oag_pkg::OAG_HI_NIBBLE_CLR, instr.operand[3:0]};
         // Post-modify lands at the end of the access, after the old value was used
         if (state == oag_pkg::OAG_ST_ACCESS && oag_is_ind(cur.op))
         begin
            if (cur.use_x)
               x_ptr <= oag_post_mod(x_ptr, cur.post);
            else
               b_ptr <= oag_post_mod(b_ptr, cur.post);
         end
         // Writes into the mapped window; a post-modify of the same pointer is overridden
         if (state == oag_pkg::OAG_ST_ACCESS && mapped_hit && oag_writes_back(cur.op))
         begin
            case (cur_addr)
               oag_pkg::OAG_ADDR_XPTR: x_ptr <= next_wdata;
               oag_pkg::OAG_ADDR_SP: stack_pointer <= next_wdata;
               oag_pkg::OAG_ADDR_BPTR: b_ptr <= next_wdata;
               oag_pkg::OAG_ADDR_SEG: seg_reg <= next_wdata;
               default: reg_file[cur_addr[3:0]] <= next_wdata;
            endcase
         end
      end
   end

endmodule : oag_operand_address_generator
`default_nettype wire

/* File: shared/oag_pkg.sv */
package oag_pkg;

   // Top sixteen bytes of a data segment
   localparam logic [7:0] OAG_REG_BASE = 8'hF0;
   localparam logic [7:0] OAG_REG_RAM_LAST = 8'hFB;
   localparam logic [7:0] OAG_ADDR_XPTR = 8'hFC;
   localparam logic [7:0] OAG_ADDR_SP = 8'hFD;
   localparam logic [7:0] OAG_ADDR_BPTR = 8'hFE;
   localparam logic [7:0] OAG_ADDR_SEG = 8'hFF;
   localparam logic [7:0] OAG_RST_PTR = 8'h00;
   localparam logic [7:0] OAG_RST_SP = 8'h6F;
   localparam logic [7:0] OAG_RST_ACC = 8'h00;
   localparam logic [14:0] OAG_RST_PC = 15'h0000;
   localparam logic [3:0] OAG_HI_NIBBLE_CLR = 4'h0;

   typedef enum logic [3:0] {
      OAG_OP_NOP = 4'h0,
      OAG_OP_LD_DIR = 4'h1,
      OAG_OP_LD_IND = 4'h2,
      OAG_OP_LD_IMM = 4'h3,
      OAG_OP_LD_BSHORT = 4'h4,
      OAG_OP_XCH_DIR = 4'h5,
      OAG_OP_XCH_IND = 4'h6,
      OAG_OP_BIT_SET = 4'h7,
      OAG_OP_BIT_CLR = 4'h8,
      OAG_OP_BIT_TST = 4'h9,
      OAG_OP_TABLE_READ = 4'hA,
      OAG_OP_ST_DIR = 4'hB
   } oag_op_t;

   typedef enum logic [1:0] {
      OAG_PM_NONE = 2'h0,
      OAG_PM_INC = 2'h1,
      OAG_PM_DEC = 2'h2
   } oag_post_t;

   typedef struct packed {
      oag_op_t op;
      logic use_x;
      oag_post_t post;
      logic [2:0] bit_sel;
      logic [7:0] operand;
   } oag_instr_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } oag_dmem_req_t;

   typedef enum logic [1:0] {
      OAG_ST_ISSUE = 2'h0,
      OAG_ST_ACCESS = 2'h1,
      OAG_ST_WRITE = 2'h2
   } oag_state_t;

endpackage : oag_pkg

/* File: verif/oag_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module oag_asserts
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire oag_pkg::oag_instr_t instr,
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire logic [14:0] pmem_addr,
   input wire logic pmem_rd,
   input wire oag_pkg::oag_dmem_req_t dmem_req,
   input wire logic [7:0] acc,
   input wire logic [7:0] x_ptr,
   input wire logic [7:0] b_ptr,
   input wire logic [7:0] stack_pointer,
   input wire logic [14:0] pc,
   input wire logic done
);
   logic tk;
   logic [7:0] cp;
   logic [14:0] ct;
   oag_pkg::oag_instr_t ci;
   assign tk = instr_valid && instr_ready;
   // Pointer and table address as they stood when the instruction was taken
   always_ff @(posedge ref_clk)
   begin
      if (tk)
      begin
         ci <= instr;
         cp <= instr.use_x ? x_ptr : b_ptr;
         ct <= {pc[14:8], acc};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   chk_short_load: assert property (tk && instr.op == oag_pkg::OAG_OP_LD_BSHORT
      |=> done && b_ptr == {4'h0, $past(instr.operand[3:0])}) else $error("short load wrong");
   chk_nop_one: assert property (tk && instr.op == oag_pkg::OAG_OP_NOP |=> done)
      else $error("nop not single cycle");
   chk_dir_addr: assert property (tk && instr.op == oag_pkg::OAG_OP_LD_DIR
      && instr.operand < oag_pkg::OAG_REG_BASE
      |=> dmem_req.rd && dmem_req.addr == $past(instr.operand)) else $error("direct addr");
   chk_xch_write: assert property (tk && instr.op == oag_pkg::OAG_OP_XCH_IND
      && (instr.use_x ? x_ptr : b_ptr) < oag_pkg::OAG_REG_BASE |=> dmem_req.rd
      ##1 (dmem_req.wr && dmem_req.addr == cp && dmem_req.wdata == $past(acc, 2)))
      else $error("exchange write wrong");
   chk_post_mod: assert property (done && ci.post == oag_pkg::OAG_PM_INC
      && ci.op == oag_pkg::OAG_OP_LD_IND |-> (ci.use_x ? x_ptr : b_ptr) == cp + 8'h01)
      else $error("post increment wrong");
   chk_table_addr: assert property (tk && instr.op == oag_pkg::OAG_OP_TABLE_READ
      |=> ##[0:1] (pmem_rd && pmem_addr == ct)) else $error("table address wrong");
   chk_reg_local: assert property (dmem_req.rd || dmem_req.wr
      |-> dmem_req.addr < oag_pkg::OAG_REG_BASE) else $error("register window went out");
   chk_reset_ptrs: assert property ($fell(sys_rst) |-> stack_pointer == oag_pkg::OAG_RST_SP
      && x_ptr == 8'h00 && b_ptr == 8'h00) else $error("pointer reset values");
   chk_ready_done: assert property (done |-> instr_ready) else $error("not ready at done");
   cover property (tk && instr.op == oag_pkg::OAG_OP_XCH_IND);
   cover property (tk && instr.op == oag_pkg::OAG_OP_TABLE_READ);
   cover property (tk && instr.op == oag_pkg::OAG_OP_BIT_TST);
endmodule : oag_asserts
bind oag_operand_address_generator oag_asserts u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .instr(instr), .instr_valid(instr_valid), .instr_ready(instr_ready),
   .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .dmem_req(dmem_req), .acc(acc), .x_ptr(x_ptr),
   .b_ptr(b_ptr), .stack_pointer(stack_pointer), .pc(pc), .done(done));
`default_nettype wire

/* File: verif/oag_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module oag_mem_model
(
   input wire logic ref_clk,
   input wire oag_pkg::oag_dmem_req_t dmem_req,
   input wire logic pmem_rd,
   input wire logic [14:0] pmem_addr,
   output logic [7:0] dmem_rdata,
   output logic [7:0] pmem_rdata
);
   logic [7:0] mem [256];
   // Answers in the cycle of the strobe; idle data is inverted so a late sample cannot pass
   assign dmem_rdata = dmem_req.rd ? mem[dmem_req.addr] : ~mem[dmem_req.addr];
   assign pmem_rdata = pmem_rd ? (pmem_addr[7:0] ^ 8'h5A) : ~(pmem_addr[7:0] ^ 8'h5A);
   always @(posedge ref_clk)
   begin
      if (dmem_req.wr)
         mem[dmem_req.addr] <= dmem_req.wdata;
   end
endmodule : oag_mem_model
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   oag_pkg::oag_instr_t instr = '0;
   logic instr_valid = 1'b0;
   logic instr_ready, pmem_rd, bit_test_result, done;
   logic [14:0] pmem_addr, pc, p;
   logic [7:0] pmem_rdata, dmem_rdata, acc, x_ptr, b_ptr, stack_pointer, seg_reg;
   oag_pkg::oag_dmem_req_t dmem_req;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc, cycles = 0;
   initial forever #5 ref_clk = ~ref_clk;
   oag_operand_address_generator u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr(instr),
      .instr_valid(instr_valid), .instr_ready(instr_ready), .pmem_addr(pmem_addr),
      .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata), .dmem_req(dmem_req),
      .dmem_rdata(dmem_rdata), .acc(acc), .x_ptr(x_ptr), .b_ptr(b_ptr),
      .stack_pointer(stack_pointer), .seg_reg(seg_reg), .pc(pc),
      .bit_test_result(bit_test_result), .done(done));
   oag_mem_model u_mem (.ref_clk(ref_clk), .dmem_req(dmem_req), .pmem_rd(pmem_rd),
      .pmem_addr(pmem_addr), .dmem_rdata(dmem_rdata), .pmem_rdata(pmem_rdata));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Holds the request until ready is seen at a falling edge and the next rising edge has passed, then counts to done
   task automatic run(input oag_pkg::oag_op_t o, input logic ux, input oag_pkg::oag_post_t pm,
      input logic [2:0] bs, input logic [7:0] od);
      @(negedge ref_clk);
      instr = '{o, ux, pm, bs, od};
      instr_valid = 1'b1;
      while (instr_ready !== 1'b1)
         @(negedge ref_clk);
      @(posedge ref_clk);
      @(negedge ref_clk);
      instr_valid = 1'b0;
      cyc = 1;
      while (done !== 1'b1 && cyc < 9)
      begin
         @(negedge ref_clk);
         cyc++;
      end
   endtask : run
   task automatic ld(input logic [7:0] a);
      run(oag_pkg::OAG_OP_LD_DIR, 1'b0, oag_pkg::OAG_PM_NONE, 3'h0, a);
   endtask : ld
   task automatic t_basic;
      chk(stack_pointer, oag_pkg::OAG_RST_SP);
      u_mem.mem[8'h05] = 8'hA6;
      ld(8'h05);
      chk(acc, 8'hA6);
      chk(16'(cyc), 16'h0002);
      run(oag_pkg::OAG_OP_NOP, 1'b0, oag_pkg::OAG_PM_NONE, 3'h0, 8'h00);
      chk(16'(cyc), 16'h0001);
      run(oag_pkg::OAG_OP_LD_BSHORT, 1'b0, oag_pkg::OAG_PM_NONE, 3'h0, 8'hA5);
      chk(b_ptr, 8'h05);
      chk(16'(cyc), 16'h0001);
      $display("basic done");
   endtask : t_basic
   task automatic t_xch;
      u_mem.mem[8'h05] = 8'h62;
      u_mem.mem[8'h06] = 8'h03;
      ld(8'h06);
      run(oag_pkg::OAG_OP_XCH_IND, 1'b0, oag_pkg::OAG_PM_INC, 3'h0, 8'h00);
      chk(acc, 8'h62);
      chk(u_mem.mem[8'h05], 8'h03);
      chk(b_ptr, 8'h06);
      run(oag_pkg::OAG_OP_XCH_DIR, 1'b0, oag_pkg::OAG_PM_NONE, 3'h0, 8'h05);
      chk(acc, 8'h03);
      chk(u_mem.mem[8'h05], 8'h62);
      chk(16'(cyc), 16'h0003);
      $display("exchange done");
   endtask : t_xch
   task automatic t_wrap;
      u_mem.mem[8'h07] = 8'hFF;
      u_mem.mem[8'h00] = 8'h5C;
      ld(8'h07);
      run(oag_pkg::OAG_OP_ST_DIR, 1'b0, oag_pkg::OAG_PM_NONE, 3'h0, oag_pkg::OAG_ADDR_XPTR);
      chk(x_ptr, 8'hFF);
      run(oag_pkg::OAG_OP_LD_IND, 1'b1, oag_pkg::OAG_PM_INC, 3'h0, 8'h00);
      chk(acc, 8'h00);
      chk(x_ptr, 8'h00);
      run(oag_pkg::OAG_OP_LD_IND, 1'b1, oag_pkg::OAG_PM_DEC, 3'h0, 8'h00);
      chk(acc, 8'h5C);
      chk(x_ptr, 8'hFF);
      run(oag_pkg::OAG_OP_ST_DIR, 1'b0, oag_pkg::OAG_PM_NONE, 3'h0, 8'hF3);
      ld(8'h05);
      ld(8'hF3);
      chk(acc, 8'h5C);
      run(oag_pkg::OAG_OP_ST_DIR, 1'b0, oag_pkg::OAG_PM_NONE, 3'h0, oag_pkg::OAG_ADDR_SEG);
      chk(seg_reg, 8'h5C);
      $display("pointer wrap done");
   endtask : t_wrap
   task automatic t_bits;
      oag_pkg::oag_op_t o [4] = '{oag_pkg::OAG_OP_BIT_SET, oag_pkg::OAG_OP_BIT_TST,
         oag_pkg::OAG_OP_BIT_CLR, oag_pkg::OAG_OP_BIT_TST};
      logic [2:0] b [4] = '{3'h5, 3'h5, 3'h0, 3'h0};
      logic [7:0] m [4] = '{8'hA1, 8'hA1, 8'hA0, 8'hA0};
      u_mem.mem[8'h20] = 8'h81;
      for (int i = 0; i < 4; i++)
      begin
         run(o[i], 1'b0, oag_pkg::OAG_PM_NONE, b[i], 8'h20);
         chk(u_mem.mem[8'h20], m[i]);
         if (i % 2 == 1)
            chk(bit_test_result, i == 1);
      end
      $display("bits done");
   endtask : t_bits
   task automatic t_prog;
      p = pc;
      run(oag_pkg::OAG_OP_LD_IMM, 1'b0, oag_pkg::OAG_PM_NONE, 3'h0, 8'h00);
      chk(acc, (p[7:0] + 8'h01) ^ 8'h5A);
      ld(8'h06);
      p = pc;
      run(oag_pkg::OAG_OP_TABLE_READ, 1'b0, oag_pkg::OAG_PM_NONE, 3'h0, 8'h00);
      chk(acc, 8'h03 ^ 8'h5A);
      chk(pc, p + 15'h0001);
      $display("program reads done");
   endtask : t_prog
   initial
   begin
      repeat (20) @(negedge ref_clk);
      sys_rst = 1'b0;
      t_basic();
      t_xch();
      t_wrap();
      t_bits();
      t_prog();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
